/* hw/dac_chain.v */
// Array-chained descriptor fetcher for the transmit and receive DMA channels
//
// Behaviour
// - One base register per direction; select low picks transmit, high picks receive.
// - 16-bit big end: address high, address low, count; six bytes per entry.
// - 16-bit little end: address low, address high, count; six bytes per entry.
// - 8-bit big end: address bytes high to low, then count high, count low.
// - Status transfer on: status at 6, length at 8, zero at 10; 12 bytes.
// - Little end keeps the extra status words at the big end offsets.
// - A zero count ends the chain; that entry's address is ignored.
// - After ending, base register points at the dummy entry start plus four.
`timescale 1ns/100ps
`include "dac_consts.vh"

module dac_chain (
  input wire mclk,
  input wire sys_rst,
  input wire chan_sel,
  input wire base_wr,
  input wire [31:0] base_wdata,
  input wire start,
  input wire bus16,
  input wire little_end,
  input wire stat_xfer_en,
  input wire [15:0] mem_rdata,
  input wire mem_ack,
  input wire buf_done,
  input wire [15:0] rx_status,
  input wire [15:0] rx_length,
  output reg mem_req_ff,
  output reg mem_we_ff,
  output reg mem_byte_ff,
  output reg [31:0] mem_addr_ff,
  output reg [15:0] mem_wdata_ff,
  output reg buf_valid_ff,
  output reg buf_chan_ff,
  output reg [31:0] buf_addr_ff,
  output reg [15:0] buf_cnt_ff,
  output reg [15:0] tx_ctrl_ff,
  output reg [15:0] tx_len_ff,
  output reg busy_ff,
  output reg chain_end_ff,
  output reg [31:0] base_rd_ff
);

  localparam ST_IDLE = 3'h0;
  localparam ST_RD = 3'h1;
  localparam ST_CHK = 3'h2;
  localparam ST_TXRD = 3'h3;
  localparam ST_BUF = 3'h4;
  localparam ST_RXWR = 3'h5;
  localparam ST_NEXT = 3'h6;

  reg [2:0] state_ff;
  reg [31:0] base_tx_ff;
  reg [31:0] base_rx_ff;
  reg [31:0] entry_ff;
  reg [3:0] ofs_ff;
  reg chan_ff;
  reg bus16_ff;
  reg little_ff;
  reg stat_ff;
  reg [15:0] rx_stat_ff;
  reg [15:0] rx_len_ff;

  wire [2:0] fld;
  wire [4:0] shift;
  wire [3:0] nxt_ofs = ofs_ff + (bus16_ff ? 4'h2 : 4'h1);
  wire [15:0] rd_lane = bus16_ff ? mem_rdata : {8'h00, mem_rdata[7:0]};
  wire [31:0] rd_placed = {16'h0000, rd_lane} << shift;
  wire [3:0] entry_len = stat_ff ? `DAC_ENTRY_STAT : `DAC_ENTRY_PLAIN;

  // Order and width are frozen at start so a mid-chain change cannot split a field
  dac_lane_map u_map (
    .ofs(ofs_ff),
    .bus16(bus16_ff),
    .little_end(little_ff),
    .fld(fld),
    .shift(shift)
  );

  function [15:0] lane_out;
    input [15:0] val;
    input [4:0] sh;
    input wide;
    reg [15:0] s;
    begin
      s = val >> sh;
      lane_out = wide ? s : {8'h00, s[7:0]};
    end
  endfunction

  reg [15:0] wr_val;
  always @* begin
    case (fld)
      `DAC_FLD_STAT: wr_val = lane_out(rx_stat_ff, shift, bus16_ff);
      `DAC_FLD_LEN: wr_val = lane_out(rx_len_ff, shift, bus16_ff);
      default: wr_val = 16'h0000;
    endcase
  end

  // One bus access: issue only; the calling state takes the ack and steps to the next lane
  task issue;
    input we;
    begin
      mem_req_ff <= 1'b1;
      mem_we_ff <= we;
      mem_byte_ff <= ~bus16_ff;
      mem_addr_ff <= entry_ff + {28'h0000000, ofs_ff};
      mem_wdata_ff <= we ? wr_val : 16'h0000;
    end
  endtask

  always @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      base_tx_ff <= `DAC_BASE_RST;
      base_rx_ff <= `DAC_BASE_RST;
      entry_ff <= 32'h0000_0000;
      ofs_ff <= 4'h0;
      chan_ff <= `DAC_CHAN_TX;
      bus16_ff <= 1'b0;
      little_ff <= 1'b0;
      stat_ff <= 1'b0;
      rx_stat_ff <= 16'h0000;
      rx_len_ff <= 16'h0000;
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_byte_ff <= 1'b0;
      mem_addr_ff <= 32'h0000_0000;
      mem_wdata_ff <= 16'h0000;
      buf_valid_ff <= 1'b0;
      buf_chan_ff <= 1'b0;
      buf_addr_ff <= 32'h0000_0000;
      buf_cnt_ff <= 16'h0000;
      tx_ctrl_ff <= 16'h0000;
      tx_len_ff <= 16'h0000;
      busy_ff <= 1'b0;
      chain_end_ff <= 1'b0;
      base_rd_ff <= `DAC_BASE_RST;
    end else begin
      chain_end_ff <= 1'b0;
      base_rd_ff <= (chan_sel == `DAC_CHAN_RX) ? base_rx_ff : base_tx_ff;
      // Writes to the copy that a running chain owns are dropped
      if (base_wr && !(busy_ff && chan_sel == chan_ff)) begin
        if (chan_sel == `DAC_CHAN_RX)
          base_rx_ff <= base_wdata;
        else
          base_tx_ff <= base_wdata;
      end
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            chan_ff <= chan_sel;
            entry_ff <= (chan_sel == `DAC_CHAN_RX) ? base_rx_ff : base_tx_ff;
            bus16_ff <= bus16;
            little_ff <= little_end;
            stat_ff <= stat_xfer_en;
            busy_ff <= 1'b1;
            ofs_ff <= 4'h0;
            buf_addr_ff <= 32'h0000_0000;
            buf_cnt_ff <= 16'h0000;
            state_ff <= ST_RD;
          end
        end
        ST_RD, ST_TXRD: begin
          if (!mem_req_ff) begin
            issue(1'b0);
          end else if (mem_ack) begin
            mem_req_ff <= 1'b0;
            ofs_ff <= nxt_ofs;
            case (fld)
              `DAC_FLD_ADDR: buf_addr_ff <= buf_addr_ff | rd_placed;
              `DAC_FLD_CNT: buf_cnt_ff <= buf_cnt_ff | rd_placed[15:0];
              `DAC_FLD_STAT: tx_ctrl_ff <= tx_ctrl_ff | rd_placed[15:0];
              `DAC_FLD_LEN: tx_len_ff <= tx_len_ff | rd_placed[15:0];
              default: ;
            endcase
            if (state_ff == ST_RD && nxt_ofs == `DAC_OFS_STAT)
              state_ff <= ST_CHK;
            else if (state_ff == ST_TXRD && nxt_ofs == `DAC_OFS_ZERO)
              state_ff <= ST_BUF;
          end
        end
        ST_CHK: begin
          if (buf_cnt_ff == 16'h0000) begin
            // Dummy entry: its address is discarded and the chain stops here
            if (chan_ff == `DAC_CHAN_RX)
              base_rx_ff <= entry_ff + {28'h0000000, `DAC_OFS_CNT};
            else
              base_tx_ff <= entry_ff + {28'h0000000, `DAC_OFS_CNT};
            busy_ff <= 1'b0;
            chain_end_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end else if (stat_ff && chan_ff == `DAC_CHAN_TX) begin
            tx_ctrl_ff <= 16'h0000;
            tx_len_ff <= 16'h0000;
            state_ff <= ST_TXRD;
          end else begin
            state_ff <= ST_BUF;
          end
        end
        ST_BUF: begin
          buf_valid_ff <= ~buf_done;
          buf_chan_ff <= chan_ff;
          if (buf_done && buf_valid_ff) begin
            rx_stat_ff <= rx_status;
            rx_len_ff <= rx_length;
            if (stat_ff && chan_ff == `DAC_CHAN_RX) begin
              ofs_ff <= `DAC_OFS_STAT;
              state_ff <= ST_RXWR;
            end else begin
              state_ff <= ST_NEXT;
            end
          end
        end
        ST_RXWR: begin
          // The zero word is written too, so the entry is always left whole
          if (!mem_req_ff) begin
            issue(1'b1);
          end else if (mem_ack) begin
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            ofs_ff <= nxt_ofs;
            if (nxt_ofs == `DAC_ENTRY_STAT)
              state_ff <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          entry_ff <= entry_ff + {28'h0000000, entry_len};
          ofs_ff <= 4'h0;
          buf_addr_ff <= 32'h0000_0000;
          buf_cnt_ff <= 16'h0000;
          state_ff <= ST_RD;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule

/* hw/dac_lane_map.v */
// Maps a byte offset within an array entry to its field and bit position
`timescale 1ns/100ps
`include "dac_consts.vh"

module dac_lane_map (
  input wire [3:0] ofs,
  input wire bus16,
  input wire little_end,
  output reg [2:0] fld,
  output reg [4:0] shift
);

  reg [3:0] fbase;
  reg [2:0] fsize;
  reg [3:0] b;
  reg [2:0] idx;
  reg [2:0] units;
  reg [1:0] bsel;

  always @* begin
    fbase = `DAC_OFS_ZERO;
    fsize = 3'h2;
    fld = `DAC_FLD_ZERO;
    if (ofs < `DAC_OFS_CNT) begin
      fld = `DAC_FLD_ADDR;
      fbase = `DAC_OFS_ADDR;
      fsize = 3'h4;
    end else if (ofs < `DAC_OFS_STAT) begin
      fld = `DAC_FLD_CNT;
      fbase = `DAC_OFS_CNT;
    end else if (ofs < `DAC_OFS_LEN) begin
      fld = `DAC_FLD_STAT;
      fbase = `DAC_OFS_STAT;
    end else if (ofs < `DAC_OFS_ZERO) begin
      fld = `DAC_FLD_LEN;
      fbase = `DAC_OFS_LEN;
    end
    b = ofs - fbase;
    // A 16-bit lane carries a whole two-byte field or a whole half of the address, so only the word order flips
    idx = bus16 ? b[3:1] : b[2:0];
    units = bus16 ? {1'b0, fsize[2:1]} : fsize;
    // Byte slot counted from the top of the field; the 2-bit wrap handles both field sizes
    bsel = 2'h3 - idx[1:0] + units[1:0];
    // Big end puts the most significant part first; extra words keep the same offsets either way
    if (little_end)
      shift = bus16 ? {idx[0], 4'h0} : {idx[1:0], 3'h0};
    else
      shift = bus16 ? {units[0] ^ idx[0] ^ 1'b1, 4'h0} : {bsel, 3'h0};
  end

endmodule

/* shared/dac_consts.vh */
// Constants for the array-chained descriptor fetcher
`ifndef DAC_CONSTS_VH
`define DAC_CONSTS_VH

// Byte offsets inside one array entry, then the plain and status entry lengths
`define DAC_OFS_ADDR 4'h0
`define DAC_OFS_CNT 4'h4
`define DAC_OFS_STAT 4'h6
`define DAC_OFS_LEN 4'h8
`define DAC_OFS_ZERO 4'ha
`define DAC_ENTRY_PLAIN 4'h6
`define DAC_ENTRY_STAT 4'hc

// Field selectors returned by the lane map
`define DAC_FLD_ADDR 3'h0
`define DAC_FLD_CNT 3'h1
`define DAC_FLD_STAT 3'h2
`define DAC_FLD_LEN 3'h3
`define DAC_FLD_ZERO 3'h4

// Channel select levels of the data/control select input
`define DAC_CHAN_TX 1'b0
`define DAC_CHAN_RX 1'b1

// Reset values
`define DAC_BASE_RST 32'h0000_0000

`endif

/* test/dac_chain_asserts.sv */
// Port-level checks for the array-chained descriptor fetcher
`timescale 1ns/100ps
module dac_chain_asserts (
  input wire mclk,
  input wire sys_rst,
  input wire start,
  input wire bus16,
  input wire mem_ack,
  input wire buf_done,
  input wire mem_req_ff,
  input wire mem_we_ff,
  input wire mem_byte_ff,
  input wire [31:0] mem_addr_ff,
  input wire buf_valid_ff,
  input wire busy_ff,
  input wire chain_end_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_wait; mem_req_ff && !mem_ack; endsequence
  sequence s_ack; mem_req_ff && mem_ack; endsequence
  req_hold_a: assert property (s_wait |=> mem_req_ff && $stable(mem_addr_ff) && $stable(mem_we_ff))
    else $error("request changed before ack");
  req_drop_a: assert property (s_ack |=> !mem_req_ff) else $error("request held after ack");
  start_go_a: assert property (start && !busy_ff |=> busy_ff ##1 mem_req_ff) else $error("start not taken");
  byte_mode_a: assert property (mem_req_ff |-> mem_byte_ff == !bus16) else $error("wrong access width");
  req_busy_a: assert property (mem_req_ff |-> busy_ff) else $error("request while idle");
  end_pulse_a: assert property (chain_end_ff |=> !chain_end_ff) else $error("end not a pulse");
  end_idle_a: assert property (chain_end_ff |-> ##[0:1] !busy_ff) else $error("busy after end");
  buf_hold_a: assert property (buf_valid_ff && !buf_done |=> buf_valid_ff) else $error("buffer lost");
  buf_drop_a: assert property (buf_valid_ff && buf_done |-> ##[1:2] !buf_valid_ff) else $error("buffer kept");
endmodule
bind dac_chain dac_chain_asserts u_chk (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .start(start),
  .bus16(bus16),
  .mem_ack(mem_ack),
  .buf_done(buf_done),
  .mem_req_ff(mem_req_ff),
  .mem_we_ff(mem_we_ff),
  .mem_byte_ff(mem_byte_ff),
  .mem_addr_ff(mem_addr_ff),
  .buf_valid_ff(buf_valid_ff),
  .busy_ff(busy_ff),
  .chain_end_ff(chain_end_ff)
);

/* test/dac_mem_model.sv */
// Byte-wide system memory answering the fetcher's requests
`timescale 1ns/100ps
module dac_mem_model (
  input wire mclk,
  input wire sys_rst,
  input wire mem_req_ff,
  input wire mem_we_ff,
  input wire mem_byte_ff,
  input wire [31:0] mem_addr_ff,
  input wire [15:0] mem_wdata_ff,
  output logic mem_ack = 1'b0,
  output logic [15:0] mem_rdata = 16'h0000
);
  logic [7:0] mem [0:255];
  int wait_n = 0;
  wire [7:0] a = mem_addr_ff[7:0];
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    // Lanes toggle when idle so a stale read never looks right
    mem_rdata <= ~mem_rdata;
    if (sys_rst) begin
      wait_n <= 0;
    end else if (mem_req_ff && !mem_ack) begin
      if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end else begin
        mem_ack <= 1'b1;
        wait_n <= $urandom_range(2);
        if (mem_we_ff && mem_byte_ff) begin
          mem[a] <= mem_wdata_ff[7:0];
        end else if (mem_we_ff) begin
          mem[a] <= mem_wdata_ff[15:8];
          mem[a + 8'h01] <= mem_wdata_ff[7:0];
        end else begin
          mem_rdata <= mem_byte_ff ? {~mem[a], mem[a]} : {mem[a], mem[a + 8'h01]};
        end
      end
    end
  end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the descriptor fetcher over all layouts
`timescale 1ns/100ps
module tb_top;
  logic mclk = 0, sys_rst = 1, chan_sel = 0, base_wr = 0, start = 0, bus16 = 0, little_end = 0;
  logic stat_xfer_en = 0, buf_done = 0;
  logic [31:0] base_wdata = 32'h0;
  logic [15:0] rx_status = 16'h0, rx_length = 16'h0;
  wire mem_req_ff, mem_we_ff, mem_byte_ff, mem_ack, buf_valid_ff, buf_chan_ff, busy_ff, chain_end_ff;
  wire [31:0] mem_addr_ff, buf_addr_ff, base_rd_ff;
  wire [15:0] mem_wdata_ff, mem_rdata, buf_cnt_ff, tx_ctrl_ff, tx_len_ff;
  int mismatches = 0, checked = 0;
  always #5 mclk = ~mclk;
  dac_chain DUT (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .chan_sel(chan_sel),
    .base_wr(base_wr),
    .base_wdata(base_wdata),
    .start(start),
    .bus16(bus16),
    .little_end(little_end),
    .stat_xfer_en(stat_xfer_en),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack),
    .buf_done(buf_done),
    .rx_status(rx_status),
    .rx_length(rx_length),
    .mem_req_ff(mem_req_ff),
    .mem_we_ff(mem_we_ff),
    .mem_byte_ff(mem_byte_ff),
    .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff),
    .buf_valid_ff(buf_valid_ff),
    .buf_chan_ff(buf_chan_ff),
    .buf_addr_ff(buf_addr_ff),
    .buf_cnt_ff(buf_cnt_ff),
    .tx_ctrl_ff(tx_ctrl_ff),
    .tx_len_ff(tx_len_ff),
    .busy_ff(busy_ff),
    .chain_end_ff(chain_end_ff),
    .base_rd_ff(base_rd_ff)
  );
  dac_mem_model M (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .mem_req_ff(mem_req_ff),
    .mem_we_ff(mem_we_ff),
    .mem_byte_ff(mem_byte_ff),
    .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );
  task tick; @(posedge mclk); #1; endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // 8-bit little end keeps the low byte first
  task put16(input int o, input logic [15:0] v);
    M.mem[o] = (!bus16 && little_end) ? v[7:0] : v[15:8];
    M.mem[o + 1] = (!bus16 && little_end) ? v[15:8] : v[7:0];
  endtask
  function logic [15:0] get16(input int o);
    return (!bus16 && little_end) ? {M.mem[o + 1], M.mem[o]} : {M.mem[o], M.mem[o + 1]};
  endfunction
  task finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    finish_test;
  end
  initial begin
    int n, st, o;
    logic c;
    logic [31:0] base, other, ad [2];
    logic [15:0] cn [2], tv [2], tl [2];
    void'($urandom(20));
    repeat (5) tick;
    sys_rst = 0;
    for (int i = 0; i < 8; i++) begin
      bus16 = i[0];
      little_end = i[1];
      stat_xfer_en = i[2];
      // Both directions meet both widths and both orders with status transfer on
      c = i[0] ^ i[1];
      st = stat_xfer_en ? 12 : 6;
      base = ($urandom & 32'hffffff00) | 32'h10;
      other = ~base;
      chan_sel = ~c;
      base_wdata = other;
      base_wr = 1;
      tick;
      chan_sel = c;
      base_wdata = base;
      tick;
      base_wr = 0;
      for (int k = 0; k < 3; k++) begin
        o = 16 + k * st;
        ad[k % 2] = $urandom;
        cn[k % 2] = (k == 2) ? 16'h0 : 16'($urandom | 1);
        tv[k % 2] = $urandom;
        tl[k % 2] = $urandom;
        put16(o, little_end ? ad[k % 2][15:0] : ad[k % 2][31:16]);
        put16(o + 2, little_end ? ad[k % 2][31:16] : ad[k % 2][15:0]);
        put16(o + 4, cn[k % 2]);
        put16(o + 6, tv[k % 2]);
        put16(o + 8, tl[k % 2]);
        put16(o + 10, 16'hffff);
      end
      start = 1;
      tick;
      start = 0;
      for (int k = 0; k < 2; k++) begin
        for (n = 0; n < 200 && buf_valid_ff !== 1'b1; n++) tick;
        chk(buf_valid_ff, 1'b1);
        o = 16 + k * st;
        ad[k] = little_end ? {get16(o + 2), get16(o)} : {get16(o), get16(o + 2)};
        chk(buf_addr_ff, ad[k]);
        chk(buf_cnt_ff, get16(o + 4));
        chk(buf_chan_ff, c);
        if (stat_xfer_en && !c) chk({tx_ctrl_ff, tx_len_ff}, {get16(o + 6), get16(o + 8)});
        rx_status = $urandom;
        rx_length = $urandom;
        tv[k] = rx_status;
        tl[k] = rx_length;
        buf_done = 1;
        tick;
        buf_done = 0;
        tick;
      end
      for (n = 0; n < 300 && chain_end_ff !== 1'b1; n++) tick;
      chk(chain_end_ff, 1'b1);
      tick;
      tick;
      chk(base_rd_ff, base + 2 * st + 4);
      chan_sel = ~c;
      tick;
      tick;
      chk(base_rd_ff, other);
      for (int k = 0; k < 2 && stat_xfer_en && c; k++) begin
        o = 16 + k * st;
        chk(get16(o + 6), tv[k]);
        chk(get16(o + 8), tl[k]);
        chk(get16(o + 10), 32'h0);
      end
    end
    finish_test;
  end
endmodule
